// [pdtt_top.v]
// processor I/O transfer decode and telemetry word tagger
`timescale 1ns/10ps
`default_nettype none
`include "pdtt_defines.vh"

// Overview of operation
// - bits 2=1, 1=0: input transfer loading adapter registers and buffers.
// - bits 2=0, 1=1: input transfer carrying a computer telemetry word.
// - bits 2,1=1 and bit 8=0: return addressed register or buffer contents.
// - bits 2,1=1 and bit 8=1: return angle count, start selected digitizer.
// - address bit eight separates digitizer group from register-read group.
// - staging data: tag bits one, two, eight decoded from address bits one, two, eight.
// - tag bit eight is 1 for computer data, 0 for staging buffer data.
// - staging data: tag bits three to seven copy address bits three to seven.
// - staging data: tag bits one, two mark input, output or digitizer word.
// - computer telemetry word tag carries address bits three to nine.
// - excitation fault monitors are read as one word at a dedicated address.
// - monitor outputs are never latched; short faults between samples are lost.
module pdtt_top (
	input  wire                       clk,
	input  wire                       srst,
	// transfer request from the computer
	input  wire                       xfer_valid,
	output wire                       xfer_ready,
	input  wire [9:1]                 xfer_addr,
	input  wire [`PDTT_WORD_W-1:0]    xfer_wdata,
	// register and buffer store of the adapter
	output wire                       reg_load,
	output wire [`PDTT_SEL_W-1:0]     reg_sel,
	output wire [`PDTT_WORD_W-1:0]    reg_wdata,
	input  wire [`PDTT_WORD_W-1:0]    reg_rdata,
	// angle digitizers
	input  wire [`PDTT_WORD_W-1:0]    angle_count_value,
	output wire                       angle_start,
	output wire [`PDTT_SEL_W-1:0]     angle_sel,
	// excitation fault monitors, live levels
	input  wire [`PDTT_MON_N-1:0]     exc_fault,
	// answer to the computer
	output wire                       rd_valid,
	output wire [`PDTT_WORD_W-1:0]    rd_data,
	output wire                       rd_bit_valid,
	output wire                       rd_bit,
	// tagged words toward the telemetry staging buffer
	output wire                       tlm_valid,
	input  wire                       tlm_ready,
	output wire [`PDTT_TAG_W-1:0]     tlm_tag,
	output wire [`PDTT_WORD_W-1:0]    tlm_data,
	// status
	output wire [4:0]                 last_group,
	output wire                       unused_seen
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	localparam [4:0] G_NONE  = `PDTT_GRP_NONE;
	localparam [4:0] G_LOAD  = `PDTT_GRP_LOAD;
	localparam [4:0] G_CTLM  = `PDTT_GRP_CTLM;
	localparam [4:0] G_READ  = `PDTT_GRP_READ;
	localparam [4:0] G_ANGLE = `PDTT_GRP_ANGLE;

	// serializer states, one-hot
	localparam [1:0] S_IDLE  = 2'b01;
	localparam [1:0] S_SHIFT = 2'b10;

	reg                          xfer_ready_r;
	reg                          reg_load_r;
	reg  [`PDTT_SEL_W-1:0]       reg_sel_r;
	reg  [`PDTT_WORD_W-1:0]      reg_wdata_r;
	reg                          angle_start_r;
	reg  [`PDTT_SEL_W-1:0]       angle_sel_r;
	reg                          rd_valid_r;
	reg  [`PDTT_WORD_W-1:0]      rd_data_r;
	reg                          rd_bit_valid_r;
	reg                          rd_bit_r;
	reg  [4:0]                   last_group_r;
	reg                          unused_seen_r;

	reg                          wr_pend_r;
	reg  [`PDTT_FIFO_W-1:0]      wr_word_r;
	reg  [`PDTT_FIFO_W-1:0]      wr_word_nxt;
	reg                          wr_pend_nxt;

	reg  [1:0]                   ser_state_r;
	reg  [1:0]                   ser_state_nxt;
	reg  [`PDTT_WORD_W-1:0]      ser_sh_r;
	reg  [`PDTT_SER_CW-1:0]      ser_cnt_r;

	reg  [4:0]                   grp;
	reg  [`PDTT_TAG_W-1:0]       tag_nxt;
	reg  [`PDTT_WORD_W-1:0]      ans_nxt;

	wire                         take;
	wire [`PDTT_SEL_W-1:0]       sel;
	wire                         mon_hit;
	wire [`PDTT_WORD_W-1:0]      mon_word;
	wire [`PDTT_FIFO_W-1:0]      fifo_out;
	wire [`PDTT_FIFO_CW-1:0]     fifo_level;
	wire [`PDTT_FIFO_CW+1:0]     fill_ahead;

	////////////////////////////////////////////////////////////////////////
	// output wiring, all from flip-flops

	assign xfer_ready   = xfer_ready_r;
	assign reg_load     = reg_load_r;
	assign reg_sel      = reg_sel_r;
	assign reg_wdata    = reg_wdata_r;
	assign angle_start  = angle_start_r;
	assign angle_sel    = angle_sel_r;
	assign rd_valid     = rd_valid_r;
	assign rd_data      = rd_data_r;
	assign rd_bit_valid = rd_bit_valid_r;
	assign rd_bit       = rd_bit_r;
	assign last_group   = last_group_r;
	assign unused_seen  = unused_seen_r;
	assign tlm_tag      = fifo_out[`PDTT_FIFO_W-1:`PDTT_WORD_W];
	assign tlm_data     = fifo_out[`PDTT_WORD_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// group decode

	assign take = xfer_valid && xfer_ready_r;
	assign sel  = xfer_addr[7:3];

	always @* begin
		grp = G_NONE;
		case (xfer_addr[2:1])
			2'b10:   grp = G_LOAD;
			2'b01:   grp = G_CTLM;
			2'b11:   grp = xfer_addr[8] ? G_ANGLE : G_READ;
			default: grp = G_NONE;
		endcase
	end

	// monitor bits are read live at the moment of the transfer, never held
	assign mon_hit  = (grp == G_READ) && (sel == `PDTT_MON_SEL);
	assign mon_word = {{(`PDTT_WORD_W-`PDTT_MON_N){1'b0}}, exc_fault};

	////////////////////////////////////////////////////////////////////////
	// tag formation

	always @* begin
		tag_nxt      = {`PDTT_TAG_W{1'b0}};
		tag_nxt[6:2] = xfer_addr[7:3];
		case (grp)
			G_LOAD: begin
				tag_nxt[`PDTT_TAG_B1] = 1'b0;
				tag_nxt[`PDTT_TAG_B2] = 1'b1;
			end
			G_CTLM: begin
				tag_nxt[`PDTT_TAG_B1] = xfer_addr[8];
				tag_nxt[`PDTT_TAG_B2] = xfer_addr[9];
				tag_nxt[`PDTT_TAG_B8] = 1'b1;
			end
			G_READ: begin
				tag_nxt[`PDTT_TAG_B1] = 1'b1;
				tag_nxt[`PDTT_TAG_B2] = 1'b0;
			end
			G_ANGLE: begin
				tag_nxt[`PDTT_TAG_B1] = 1'b0;
				tag_nxt[`PDTT_TAG_B2] = 1'b0;
			end
			default: tag_nxt = {`PDTT_TAG_W{1'b0}};
		endcase
	end

	// word returned to the computer for the two output groups
	always @* begin
		ans_nxt = `PDTT_WORD_RST;
		case (grp)
			G_READ:  ans_nxt = mon_hit ? mon_word : reg_rdata;
			G_ANGLE: ans_nxt = angle_count_value;
			default: ans_nxt = `PDTT_WORD_RST;
		endcase
	end

	// every used group leaves one tagged word for telemetry
	always @* begin
		wr_pend_nxt = 1'b0;
		wr_word_nxt = wr_word_r;
		if (take && (grp != G_NONE)) begin
			wr_pend_nxt = 1'b1;
			case (grp)
				G_LOAD:  wr_word_nxt = {tag_nxt, xfer_wdata};
				G_CTLM:  wr_word_nxt = {tag_nxt, xfer_wdata};
				default: wr_word_nxt = {tag_nxt, ans_nxt};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// back-pressure: a taken transfer lands in the fifo one clock later,
	// so readiness looks two writes ahead and ignores reads (conservative)

	assign fill_ahead = {2'b00, fifo_level} + {4'h0, wr_pend_r} + {4'h0, take};

	always @(posedge clk) begin
		if (srst) begin
			xfer_ready_r <= 1'b0;
		end else begin
			xfer_ready_r <= (fill_ahead < `PDTT_FIFO_DEPTH);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transfer actions

	always @(posedge clk) begin
		if (srst) begin
			reg_load_r    <= 1'b0;
			reg_sel_r     <= `PDTT_SEL_RST;
			reg_wdata_r   <= `PDTT_WORD_RST;
			angle_start_r <= 1'b0;
			angle_sel_r   <= `PDTT_SEL_RST;
			rd_valid_r    <= 1'b0;
			rd_data_r     <= `PDTT_WORD_RST;
			last_group_r  <= G_NONE;
			unused_seen_r <= 1'b0;
			wr_pend_r     <= 1'b0;
			wr_word_r     <= {`PDTT_FIFO_W{1'b0}};
		end else begin
			reg_load_r    <= 1'b0;
			angle_start_r <= 1'b0;
			rd_valid_r    <= 1'b0;
			unused_seen_r <= 1'b0;
			wr_pend_r     <= wr_pend_nxt;
			wr_word_r     <= wr_word_nxt;
			if (take) begin
				last_group_r <= grp;
				case (grp)
					G_LOAD: begin
						reg_load_r  <= 1'b1;
						reg_sel_r   <= sel;
						reg_wdata_r <= xfer_wdata;
					end
					G_READ: begin
						rd_valid_r <= 1'b1;
						rd_data_r  <= ans_nxt;
					end
					G_ANGLE: begin
						rd_valid_r    <= 1'b1;
						rd_data_r     <= ans_nxt;
						angle_start_r <= 1'b1;
						angle_sel_r   <= sel;
					end
					G_CTLM: begin
						rd_valid_r <= 1'b0;
					end
					default: begin
						unused_seen_r <= 1'b1;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial return: the parallel answer is also shifted out lsb first,
	// a new read restarts the shift and abandons the old word

	always @* begin
		ser_state_nxt = ser_state_r;
		case (ser_state_r)
			S_IDLE: begin
				if (rd_valid_r) begin
					ser_state_nxt = S_SHIFT;
				end
			end
			S_SHIFT: begin
				if (!rd_valid_r && (ser_cnt_r == `PDTT_SER_LEN - 5'h01)) begin
					ser_state_nxt = S_IDLE;
				end
			end
			default: ser_state_nxt = S_IDLE;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			ser_state_r    <= S_IDLE;
			ser_sh_r       <= `PDTT_WORD_RST;
			ser_cnt_r      <= {`PDTT_SER_CW{1'b0}};
			rd_bit_valid_r <= 1'b0;
			rd_bit_r       <= 1'b0;
		end else begin
			ser_state_r <= ser_state_nxt;
			if (rd_valid_r) begin
				ser_sh_r       <= {1'b0, rd_data_r[`PDTT_WORD_W-1:1]};
				ser_cnt_r      <= {`PDTT_SER_CW{1'b0}};
				rd_bit_valid_r <= 1'b1;
				rd_bit_r       <= rd_data_r[0];
			end else if (ser_state_r == S_SHIFT &&
				ser_cnt_r != `PDTT_SER_LEN - 5'h01) begin
				ser_sh_r       <= {1'b0, ser_sh_r[`PDTT_WORD_W-1:1]};
				ser_cnt_r      <= ser_cnt_r + 5'h01;
				rd_bit_valid_r <= 1'b1;
				rd_bit_r       <= ser_sh_r[0];
			end else begin
				rd_bit_valid_r <= 1'b0;
				rd_bit_r       <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// staging fifo toward telemetry

	pdtt_fifo #(
		.WIDTH (`PDTT_FIFO_W),
		.DEPTH (`PDTT_FIFO_DEPTH),
		.AW    (`PDTT_FIFO_AW),
		.CW    (`PDTT_FIFO_CW)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (wr_pend_r),
		.in_ready  (),
		.in_data   (wr_word_r),
		.out_valid (tlm_valid),
		.out_ready (tlm_ready),
		.out_data  (fifo_out),
		.level     (fifo_level)
	);

endmodule
`default_nettype wire

// [pdtt_defines.vh]
// constants for the processor I/O decode and telemetry tagger
`ifndef PDTT_DEFINES_VH
`define PDTT_DEFINES_VH

// transfer groups, one-hot, decoded from address bits 1, 2 and 8
`define PDTT_GRP_NONE      5'h01
`define PDTT_GRP_LOAD      5'h02
`define PDTT_GRP_CTLM      5'h04
`define PDTT_GRP_READ      5'h08
`define PDTT_GRP_ANGLE     5'h10

// word and tag widths
`define PDTT_WORD_W        26
`define PDTT_TAG_W         8
`define PDTT_SEL_W         5
`define PDTT_FIFO_W        34
`define PDTT_FIFO_DEPTH    4
`define PDTT_FIFO_AW       2
`define PDTT_FIFO_CW       3

// tag field positions (tag bit n sits at index n-1)
`define PDTT_TAG_B1        0
`define PDTT_TAG_B2        1
`define PDTT_TAG_B8        7

// excitation monitor word
`define PDTT_MON_N         18
`define PDTT_MON_SEL       5'h1f

// serial return of a read word, one bit per clock
`define PDTT_SER_LEN       5'h1a
`define PDTT_SER_CW        5

// reset values
`define PDTT_WORD_RST      26'h0000000
`define PDTT_SEL_RST       5'h00

`endif

// [pdtt_fifo.v]
// small synchronous fifo with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "pdtt_defines.vh"

module pdtt_fifo #(
	parameter WIDTH = `PDTT_FIFO_W,
	parameter DEPTH = `PDTT_FIFO_DEPTH,
	parameter AW    = `PDTT_FIFO_AW,
	parameter CW    = `PDTT_FIFO_CW
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [CW-1:0]    level
);

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_r;
	reg  [AW-1:0]    rd_ptr_r;
	reg  [CW-1:0]    cnt_r;
	reg              out_valid_r;
	reg  [WIDTH-1:0] out_data_r;
	wire             push;
	wire             pop;

	////////////////////////////////////////////////////////////////////////
	// full and empty come straight from the count
	assign in_ready  = (cnt_r != DEPTH[CW-1:0]);
	assign push      = in_valid && in_ready;
	assign pop       = (cnt_r != {CW{1'b0}}) && (!out_valid_r || out_ready);
	assign out_valid = out_valid_r;
	assign out_data  = out_data_r;
	assign level     = cnt_r;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			wr_ptr_r    <= {AW{1'b0}};
			rd_ptr_r    <= {AW{1'b0}};
			cnt_r       <= {CW{1'b0}};
			out_valid_r <= 1'b0;
			out_data_r  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r    <= rd_ptr_r + 1'b1;
				out_data_r  <= mem[rd_ptr_r];
				out_valid_r <= 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
			case ({push, pop})
				2'b10:   cnt_r <= cnt_r + 1'b1;
				2'b01:   cnt_r <= cnt_r - 1'b1;
				default: cnt_r <= cnt_r;
			endcase
		end
	end

endmodule
`default_nettype wire

// [pdtt_asserts.sv]
// port checker for the transfer decode and telemetry tagger
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
module pdtt_asserts (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        xfer_valid,
	input wire logic        xfer_ready,
	input wire logic [9:1]  xfer_addr,
	input wire logic [25:0] reg_rdata,
	input wire logic [17:0] exc_fault,
	input wire logic        reg_load,
	input wire logic [4:0]  reg_sel,
	input wire logic        angle_start,
	input wire logic [4:0]  angle_sel,
	input wire logic        rd_valid,
	input wire logic [25:0] rd_data,
	input wire logic        rd_bit,
	input wire logic        tlm_valid,
	input wire logic        tlm_ready,
	input wire logic [7:0]  tlm_tag,
	input wire logic [25:0] tlm_data,
	input wire logic        unused_seen
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire       tk = xfer_valid && xfer_ready;
	wire [1:0] lo = xfer_addr[2:1];
	wire       rd = tk && lo == 2'b11 && !xfer_addr[8];

	load_decode_a: assert property (
		tk && lo == 2'b10 |=> reg_load && reg_sel == $past(xfer_addr[7:3]))
		else $error("load not decoded");
	load_cause_a: assert property (
		reg_load |-> $past(tk && lo == 2'b10))
		else $error("load without a load transfer");
	angle_start_a: assert property (
		tk && lo == 2'b11 && xfer_addr[8] |=> angle_start && angle_sel == $past(xfer_addr[7:3]))
		else $error("digitizer not started");
	read_data_a: assert property (
		rd && xfer_addr[7:3] != 5'h1f |=> rd_valid && !angle_start && rd_data == $past(reg_rdata))
		else $error("read answer wrong");
	mon_live_a: assert property (
		rd && xfer_addr[7:3] == 5'h1f |=> rd_data == {8'h00, $past(exc_fault)})
		else $error("monitor word wrong");
	unused_quiet_a: assert property (
		tk && lo == 2'b00 |=> unused_seen && !reg_load && !angle_start && !rd_valid)
		else $error("unused transfer acted on");
	serial_first_a: assert property (
		rd_valid |=> rd_bit == $past(rd_data[0]))
		else $error("serial answer bit wrong");
	tlm_hold_a: assert property (
		tlm_valid && !tlm_ready |=> tlm_valid && $stable(tlm_tag) && $stable(tlm_data))
		else $error("telemetry word dropped while stalled");
	dom_code_a: assert property (
		tlm_valid && !tlm_tag[7] |-> tlm_tag[1:0] != 2'b11)
		else $error("staging tag code invalid");

	cover property (tk && lo == 2'b01);
	cover property (tlm_valid && !tlm_ready);
	cover property (angle_start);
endmodule
bind pdtt_top pdtt_asserts pdtt_asserts_i (.*);
`default_nettype wire

// [pdtt_store_model.sv]
// behavioural register store and angle digitizer beside the adapter
`timescale 1ns/10ps
`default_nettype none
module pdtt_store_model (
	input  wire logic        clk,
	input  wire logic        reg_load,
	input  wire logic [4:0]  reg_sel,
	input  wire logic [25:0] reg_wdata,
	input  wire logic [4:0]  rd_sel,
	output var  logic [25:0] reg_rdata,
	input  wire logic        angle_start,
	input  wire logic [4:0]  angle_sel,
	output var  logic [25:0] angle_count_value
);
	logic [25:0] mem [0:31];
	// unwritten entries hold a pattern, so a stale zero cannot pass
	initial begin
		for (int i = 0; i < 32; i++)
			mem[i] = 26'h2aaaaaa ^ i;
		angle_count_value = 26'h0000abc;
	end
	assign reg_rdata = mem[rd_sel];
	always @(posedge clk) begin
		if (reg_load)
			mem[reg_sel] <= reg_wdata;
		if (angle_start)
			angle_count_value <= 26'h1000000 | angle_sel;
	end
endmodule
`default_nettype wire

// [tb_pio_decode_telemetry_tagger.sv]
// self-checking bench for the transfer decode and telemetry tagger
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_pio_decode_telemetry_tagger;
	logic        clk = 0, srst = 1, xfer_valid = 0, tlm_ready = 1;
	logic [9:1]  xfer_addr = 0, a;
	logic [25:0] xfer_wdata = 0, reg_rdata, angle_count_value, reg_wdata, rd_data, tlm_data, d;
	logic [25:0] cnt = 26'h0000abc;
	logic [17:0] exc_fault = 0;
	logic        xfer_ready, reg_load, angle_start, rd_valid, rd_bit_valid, rd_bit;
	logic        tlm_valid, unused_seen;
	logic [4:0]  reg_sel, angle_sel, last_group;
	logic [7:0]  tlm_tag;
	logic [33:0] exp_q[$];
	int          n_mismatch = 0, n_tests = 0;

	always #20 clk = ~clk;
	pdtt_top pdtt_top_i (.*);
	pdtt_store_model pdtt_store_model_i (.*, .rd_sel(xfer_addr[7:3]));
	////////////////////////////////////////
	always @(posedge clk)
		if (!srst && tlm_valid && tlm_ready) begin
			`CHK("tlm word", exp_q.size() ? exp_q[0] : 34'h0, {tlm_tag, tlm_data})
			if (exp_q.size())
				void'(exp_q.pop_front());
		end

	task automatic xfer(input logic [9:1] ad, input logic [25:0] wd, input logic [33:0] e,
			input bit t);
		int k = 0;
		// one idle edge so a valid just lowered is never raised in the same step
		@(posedge clk) #1;
		xfer_addr = ad;
		xfer_wdata = wd;
		xfer_valid = 1;
		while (xfer_ready !== 1'b1 && k < 200) begin
			@(posedge clk) #1;
			k++;
		end
		if (t)
			exp_q.push_back(e);
		@(posedge clk) #1;
		xfer_valid = 0;
	endtask

	task report_and_stop;
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		#1 srst = 0;
		repeat (2) @(posedge clk) #1;
		for (int i = 0; i < 4; i++) begin
			a = {2'b00, 5'(i * 9 + 2), 2'b10};
			d = 26'h155aa00 + i;
			xfer(a, d, {1'b0, a[7:3], 2'b10, d}, 1);
			`CHK("load", {1'b1, a[7:3], d}, {reg_load, reg_sel, reg_wdata})
		end
		for (int i = 0; i < 4; i++) begin
			a = {2'b00, 5'(i * 9 + 2), 2'b11};
			d = 26'h155aa00 + i;
			xfer(a, 0, {1'b0, a[7:3], 2'b01, d}, 1);
			`CHK("read", {2'b10, d}, {rd_valid, angle_start, rd_data})
		end
		for (int b = 0; b < 26; b++) begin
			@(posedge clk) #1;
			`CHK("rd_bit", {1'b1, d[b]}, {rd_bit_valid, rd_bit})
		end
		for (int i = 0; i < 4; i++) begin
			a = {2'(i), 5'(i + 7), 2'b01};
			d = 26'h2000000 | i;
			xfer(a, d, {1'b1, a[7:3], a[9], a[8], d}, 1);
			`CHK("ctlm quiet", 2'b00, {reg_load, rd_valid})
		end
		// the second read must see the count of the digitizer the first one started
		for (int i = 0; i < 2; i++) begin
			a = {2'b01, 5'(i + 5), 2'b11};
			xfer(a, 0, {1'b0, a[7:3], 2'b00, cnt}, 1);
			`CHK("angle count", cnt, rd_data)
			`CHK("angle start", {1'b1, a[7:3]}, {angle_start, angle_sel})
			cnt = 26'h1000000 | a[7:3];
		end
		exc_fault = 18'h2a5c3;
		xfer(9'h07f, 0, {1'b0, 5'h1f, 2'b01, 26'h002a5c3}, 1);
		`CHK("monitor", 26'h002a5c3, rd_data)
		exc_fault = 18'h0;
		xfer(9'h07f, 0, {1'b0, 5'h1f, 2'b01, 26'h0}, 1);
		`CHK("monitor cleared", 26'h0, rd_data)
		xfer(9'h0fc, 26'h3ffffff, 0, 0);
		`CHK("unused", 9'h101, {unused_seen, reg_load, angle_start, rd_valid, last_group})
		repeat (8) @(posedge clk) #1;
		tlm_ready = 0;
		// four in the fifo plus one in its output register
		for (int i = 0; i < 5; i++)
			xfer({2'b10, 5'(i), 2'b01}, 26'(i), {1'b1, 5'(i), 2'b10, 26'(i)}, 1);
		repeat (3) @(posedge clk) #1;
		`CHK("ready when full", 1'b0, xfer_ready)
		tlm_ready = 1;
		xfer(9'h125, 26'h5, {1'b1, 5'h09, 2'b10, 26'h5}, 1);
		repeat (12) @(posedge clk) #1;
		`CHK("drained", 0, exp_q.size())
		report_and_stop;
	end

	initial begin
		#800000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
`default_nettype wire
